/* spp_port.sv */
// six-pin port with pin functions, AHB-Lite register slave
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module spp_port
   import spp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [5:0] padIn,
   input wire spp_sfin_t sfIn,
   input wire logic [1:0] opMode,
   input wire logic optExtReset,
   input wire logic optClkOut,
   input wire logic optPwm,
   input wire logic optBuzzer,
   output spp_pad_t padOut,
   output spp_route_t route,
   output logic irqReq,
   output logic extResetReq
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [5:0] dataReg, dirReg, pullUpReg, odReg, wakeReg;
   logic [7:0] pullDnReg, irqFlagReg, irqEnReg, pwrReg, edgeReg, carrReg;
   logic [7:0] tmrSelReg, tmrBReg, buzzReg, touchReg;
   logic [9:0] miscReg;
   logic [5:0] pinPrev;
   logic [7:0] wAddr;
   logic wPend, rPend;
   logic [7:0] rdMux;
   logic [31:0] rdNext;
   logic [7:0] bankRd;
   logic bankWr;
   // ----------------------------------------------------------------
   // bus slave: zero wait state, always OKAY
   // ----------------------------------------------------------------
   wire logic accept = hsel && hready && (htrans == SPP_HTRANS_NONSEQ);
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wPend <= 1'b0;
         rPend <= 1'b0;
         wAddr <= SPP_RST8;
      end else begin
         wPend <= accept && hwrite;
         rPend <= accept && !hwrite;
         if (accept) begin
            wAddr <= haddr;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   wire logic wr = wPend;
   wire logic [7:0] wd = hwdata[7:0];
   logic [4:0] bankAddrReg;
   logic [4:0] bankRdAddr;
   // hold the bank address between reads so bank read data stand through the data phase
   assign bankRdAddr = (accept && !hwrite) ? haddr[6:2] : bankAddrReg;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bankAddrReg <= SPP_RST8[4:0];
      end else if (accept && !hwrite) begin
         bankAddrReg <= haddr[6:2];
      end
   end
   // unmapped words above the misc register land in a scratch bank so software can still probe them
   assign bankWr = wr && (wAddr[7:2] > SPP_OFF_MISC[7:2]);
   spp_regbank u_bank (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wrEn(bankWr),
      .wrAddr(wAddr[6:2]),
      .wrData(wd),
      .rdAddr(bankRdAddr),
      .rdData(bankRd)
   );
   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dataReg <= SPP_RST6;
         dirReg <= SPP_RST6;
         pullUpReg <= SPP_RST6;
         pullDnReg <= SPP_RST8;
         odReg <= SPP_RST6;
         wakeReg <= SPP_RST6;
      end else if (wr) begin
         case (wAddr)
            SPP_OFF_DATA: dataReg <= wd[5:0];
            SPP_OFF_DIR: dirReg <= wd[5:0];
            SPP_OFF_PULLUP: pullUpReg <= wd[5:0];
            SPP_OFF_PULLDN: pullDnReg <= {wd[7:4], 4'h0};
            SPP_OFF_ODRAIN: odReg <= wd[5:0];
            SPP_OFF_WAKE: wakeReg <= wd[5:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irqEnReg <= SPP_RST8;
         pwrReg <= SPP_RST8;
         edgeReg <= SPP_RST8;
         carrReg <= SPP_RST8;
         tmrSelReg <= SPP_RST8;
         tmrBReg <= SPP_RST8;
         buzzReg <= SPP_RST8;
         touchReg <= SPP_RST8;
         miscReg <= SPP_RST10;
      end else if (wr) begin
         case (wAddr)
            SPP_OFF_IRQE: irqEnReg <= wd;
            SPP_OFF_PWR: pwrReg <= wd;
            SPP_OFF_EDGE: edgeReg <= wd;
            SPP_OFF_CARR: carrReg <= wd;
            SPP_OFF_TMRSEL: tmrSelReg <= wd;
            SPP_OFF_TMRB: tmrBReg <= wd;
            SPP_OFF_BUZZ: buzzReg <= wd;
            SPP_OFF_TOUCH: touchReg <= {4'h0, wd[3:0]};
            SPP_OFF_MISC: miscReg <= {hwdata[9:8], wd};
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // change detection and external interrupt edge
   // ----------------------------------------------------------------
   wire logic extSel = edgeReg[SPP_EIS_BIT];
   wire logic [5:0] wakeMask = {wakeReg[5:1], wakeReg[0] & ~extSel};
   wire logic [5:0] pinChg = (padIn ^ pinPrev) & wakeMask;
   // edge bit 1 = falling, 0 = rising
   wire logic extEdge = extSel && (edgeReg[SPP_EDGE_BIT] ?
      (pinPrev[0] && !padIn[0]) : (!pinPrev[0] && padIn[0]));
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pinPrev <= SPP_RST6;
      end else begin
         pinPrev <= padIn;
      end
   end
   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irqFlagReg <= SPP_RST8;
      end else begin
         if (wr && wAddr == SPP_OFF_IRQF) begin
            irqFlagReg <= wd;
         end
         if (|pinChg) begin
            irqFlagReg[SPP_PORTCHG_BIT] <= 1'b1;
         end
         if (extEdge) begin
            irqFlagReg[SPP_EXTIF_BIT] <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= pwrReg[SPP_GIE_BIT] && |(irqFlagReg & irqEnReg);
      end
   end
   // ----------------------------------------------------------------
   // pin function routing
   // ----------------------------------------------------------------
   logic [5:0] special_func_enable, sfVal;
   logic pwmOn, buzzOn, clkOn;
   always_comb begin
      pwmOn = tmrBReg[SPP_PWMOE_BIT] && optPwm;
      buzzOn = buzzReg[SPP_BUZZ_BIT] && optBuzzer;
      clkOn = optClkOut && (opMode == SPP_MODE_NORMAL || opMode == SPP_MODE_STANDBY);
      special_func_enable = 6'h00;
      sfVal = 6'h00;
      special_func_enable[2] = pwmOn || buzzOn;
      sfVal[2] = pwmOn ? sfIn.pwm : sfIn.buzzer;
      special_func_enable[3] = carrReg[SPP_CARR_BIT];
      sfVal[3] = sfIn.carrier;
      special_func_enable[4] = clkOn;
      sfVal[4] = sfIn.instrClk;
   end
   wire logic [5:0] touchMask = {touchReg[3], touchReg[2], 1'b0, touchReg[1], 1'b0, touchReg[0]};
   logic [5:0] pinDrv, pinVal, pinOe, pinPu, pinPd;
   genvar gi;
   generate
      for (gi = 0; gi < SPP_PINS; gi++) begin : g_pin
         // dir bit 1 = input; special function forces output unless the pin is selected as a touch pad
         assign pinDrv[gi] = (special_func_enable[gi] || !dirReg[gi]) && !touchMask[gi];
         assign pinVal[gi] = special_func_enable[gi] ? sfVal[gi] : dataReg[gi];
         assign pinOe[gi] = pinDrv[gi] && !(odReg[gi] && pinVal[gi]);
         assign pinPu[gi] = !pinDrv[gi] && pullUpReg[gi];
         assign pinPd[gi] = !pinDrv[gi] && (gi < 4) && pullDnReg[SPP_PD_LSB + (gi % 4)];
      end
   endgenerate
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         padOut <= '0;
      end else begin
         padOut.dataOut <= pinVal;
         padOut.outEn <= pinOe;
         padOut.pullUpEn <= pinPu;
         padOut.pullDownEn <= pinPd;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         route <= '0;
         extResetReq <= 1'b0;
      end else begin
         route.touchPad <= touchReg[3:0];
         route.cmp0 <= miscReg[SPP_MISC_CMP0];
         route.cmp2 <= miscReg[SPP_MISC_CMP2];
         route.capConnect <= miscReg[SPP_MISC_CAPEN];
         route.capDischarge <= miscReg[SPP_MISC_CAPEN] && miscReg[SPP_MISC_DISCH];
         route.timerAClk <= tmrSelReg[SPP_TA_SRC_BIT] && !tmrSelReg[SPP_TA_LCK_BIT] && padIn[5];
         route.timerBClk <= tmrSelReg[SPP_TB_SRC_BIT] && padIn[5];
         extResetReq <= optExtReset && !padIn[3];
      end
   end
   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdMux = SPP_RST8;
      case (haddr)
         SPP_OFF_DATA: rdMux = {2'h0, miscReg[SPP_MISC_RDLATCH] ? dataReg : padIn};
         SPP_OFF_DIR: rdMux = {2'h0, dirReg};
         SPP_OFF_PULLUP: rdMux = {2'h0, pullUpReg};
         SPP_OFF_PULLDN: rdMux = pullDnReg;
         SPP_OFF_ODRAIN: rdMux = {2'h0, odReg};
         SPP_OFF_WAKE: rdMux = {2'h0, wakeReg};
         SPP_OFF_IRQF: rdMux = irqFlagReg;
         SPP_OFF_IRQE: rdMux = irqEnReg;
         SPP_OFF_PWR: rdMux = pwrReg;
         SPP_OFF_EDGE: rdMux = edgeReg;
         SPP_OFF_CARR: rdMux = carrReg;
         SPP_OFF_TMRSEL: rdMux = tmrSelReg;
         SPP_OFF_TMRB: rdMux = tmrBReg;
         SPP_OFF_BUZZ: rdMux = buzzReg;
         SPP_OFF_TOUCH: rdMux = touchReg;
         SPP_OFF_MISC: rdMux = miscReg[7:0];
         default: rdMux = SPP_RST8;
      endcase
      rdNext = {24'h000000, rdMux};
      if (haddr == SPP_OFF_MISC) begin
         rdNext = {22'h000000, miscReg};
      end
   end
   logic [31:0] rdHold;
   logic rdFromBank;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdHold <= 32'h00000000;
         rdFromBank <= 1'b0;
      end else if (accept && !hwrite) begin
         rdHold <= rdNext;
         rdFromBank <= haddr[7:2] > SPP_OFF_MISC[7:2];
      end
   end
   always_comb begin
      hrdata = rdFromBank ? {24'h000000, bankRd} : rdHold;
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_chg;
      @(posedge clk_sys) disable iff (!rst_n) (|pinChg) |=> irqFlagReg[SPP_PORTCHG_BIT];
   endproperty
   a_chg: assert property (p_chg) else $error("port change flag not set");
   property p_irq;
      @(posedge clk_sys) disable iff (!rst_n)
         irqReq |-> $past(pwrReg[SPP_GIE_BIT]);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without global enable");
   property p_mask0;
      @(posedge clk_sys) disable iff (!rst_n)
         extSel && (padIn[0] != pinPrev[0]) && !(|pinChg[5:1]) &&
         !irqFlagReg[SPP_PORTCHG_BIT] && !(wr && wAddr == SPP_OFF_IRQF)
         |=> !irqFlagReg[SPP_PORTCHG_BIT];
   endproperty
   a_mask0: assert property (p_mask0) else $error("pin0 change not masked");
   property p_pd;
      @(posedge clk_sys) disable iff (!rst_n) ##1 !padOut.pullDownEn[5] && !padOut.pullDownEn[4];
   endproperty
   a_pd: assert property (p_pd) else $error("pull-low on upper pins");
   property p_carr;
      @(posedge clk_sys) disable iff (!rst_n)
         carrReg[SPP_CARR_BIT] && !touchMask[3] |=> padOut.dataOut[3] == $past(sfIn.carrier);
   endproperty
   a_carr: assert property (p_carr) else $error("carrier not on pin3");
   property p_rst;
      @(posedge clk_sys) disable iff (!rst_n) optExtReset && !padIn[3] |=> extResetReq;
   endproperty
   a_rst: assert property (p_rst) else $error("external reset missed");
   property p_od;
      @(posedge clk_sys) disable iff (!rst_n)
         odReg[1] && !special_func_enable[1] && dataReg[1] |=> !padOut.outEn[1];
   endproperty
   a_od: assert property (p_od) else $error("open-drain drove high");
   property p_in;
      @(posedge clk_sys) disable iff (!rst_n) dirReg[0] && !special_func_enable[0] |=> !padOut.outEn[0];
   endproperty
   a_in: assert property (p_in) else $error("input pin driven");
   property p_touch0;
      @(posedge clk_sys) disable iff (!rst_n) touchReg[0] |=> !padOut.outEn[0];
   endproperty
   a_touch0: assert property (p_touch0) else $error("touch pin driven");
endmodule : spp_port

/* spp_pkg.sv */
// package: register map, field positions and carrier types of the six-pin port
package spp_pkg;
   localparam int SPP_PINS = 6;
   localparam logic [7:0] SPP_OFF_DATA = 8'h00;
   localparam logic [7:0] SPP_OFF_DIR = 8'h04;
   localparam logic [7:0] SPP_OFF_PULLUP = 8'h08;
   localparam logic [7:0] SPP_OFF_PULLDN = 8'h0c;
   localparam logic [7:0] SPP_OFF_ODRAIN = 8'h10;
   localparam logic [7:0] SPP_OFF_WAKE = 8'h14;
   localparam logic [7:0] SPP_OFF_IRQF = 8'h18;
   localparam logic [7:0] SPP_OFF_IRQE = 8'h1c;
   localparam logic [7:0] SPP_OFF_PWR = 8'h20;
   localparam logic [7:0] SPP_OFF_EDGE = 8'h24;
   localparam logic [7:0] SPP_OFF_CARR = 8'h28;
   localparam logic [7:0] SPP_OFF_TMRSEL = 8'h2c;
   localparam logic [7:0] SPP_OFF_TMRB = 8'h30;
   localparam logic [7:0] SPP_OFF_BUZZ = 8'h34;
   // the touch register is known by its word index; its byte address is four times that
   localparam logic [7:0] SPP_IDX_TOUCH = 8'h0f;
   localparam logic [7:0] SPP_OFF_TOUCH = {SPP_IDX_TOUCH[5:0], 2'h0};
   localparam logic [7:0] SPP_OFF_MISC = 8'h40;
   localparam int SPP_PORTCHG_BIT = 1;
   localparam int SPP_GIE_BIT = 7;
   localparam int SPP_EIS_BIT = 4;
   localparam int SPP_EDGE_BIT = 0;
   localparam int SPP_EXTIF_BIT = 2;
   localparam int SPP_CARR_BIT = 0;
   localparam int SPP_PWMOE_BIT = 7;
   localparam int SPP_BUZZ_BIT = 7;
   localparam int SPP_TA_SRC_BIT = 5;
   localparam int SPP_TA_LCK_BIT = 7;
   localparam int SPP_TB_SRC_BIT = 4;
   localparam int SPP_PD_LSB = 4;
   localparam int SPP_MISC_RDLATCH = 0;
   localparam int SPP_MISC_CAPEN = 6;
   localparam int SPP_MISC_DISCH = 7;
   localparam int SPP_MISC_CMP0 = 8;
   localparam int SPP_MISC_CMP2 = 9;
   localparam logic [5:0] SPP_RST6 = 6'h00;
   localparam logic [7:0] SPP_RST8 = 8'h00;
   localparam logic [9:0] SPP_RST10 = 10'h000;
   localparam logic [1:0] SPP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] SPP_MODE_NORMAL = 2'h0;
   localparam logic [1:0] SPP_MODE_STANDBY = 2'h2;
   typedef struct packed {
      logic [5:0] dataOut;
      logic [5:0] outEn;
      logic [5:0] pullUpEn;
      logic [5:0] pullDownEn;
   } spp_pad_t;
   typedef struct packed {
      logic pwm;
      logic buzzer;
      logic carrier;
      logic instrClk;
   } spp_sfin_t;
   typedef struct packed {
      logic [3:0] touchPad;
      logic cmp0;
      logic cmp2;
      logic capConnect;
      logic capDischarge;
      logic timerAClk;
      logic timerBClk;
   } spp_route_t;
endpackage : spp_pkg

/* spp_regbank.sv */
// small register memory: eight-bit words, registered read data
`timescale 1ns/1ps
module spp_regbank
   import spp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [4:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [4:0] rdAddr,
   output logic [7:0] rdData
);
   logic [7:0] mem [0:31];
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdData <= SPP_RST8;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule : spp_regbank

/* spp_board.sv */
// board model: external drivers, pull resistors and floating pads of the six pins
`timescale 1ns/1ps
module spp_board
   import spp_pkg::*;
(
   input wire logic clk_sys,
   input wire spp_pad_t padOut,
   input wire logic [5:0] extEn,
   input wire logic [5:0] extVal,
   output logic [5:0] padIn
);
   logic [5:0] floatLvl = 6'h15;

   // an undriven pad without pull resistor wanders every cycle
   always_ff @(posedge clk_sys) begin
      floatLvl <= ~padIn;
   end

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         padIn[i] = padOut.outEn[i] ? padOut.dataOut[i] : extEn[i] ? extVal[i] :
                    padOut.pullUpEn[i] ? 1'b1 : padOut.pullDownEn[i] ? 1'b0 : floatLvl[i];
      end
   end
endmodule : spp_board

/* spp_port_tb_top.sv */
// testbench: bus stimulus and pad behaviour checks for the six-pin port
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module spp_port_tb_top
   import spp_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n, hsel, hwrite, hreadyout, hresp, irqReq, extResetReq;
   logic optExtReset, optClkOut, optPwm, optBuzzer;
   logic [7:0] haddr;
   logic [1:0] htrans, opMode;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [5:0] padIn, extEn, extVal;
   spp_sfin_t sfIn;
   spp_pad_t padOut;
   spp_route_t route;
   int badCount = 0;
   int comparisons = 0;

   always #25 clk_sys = ~clk_sys;

   spp_port u_spp_port (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .padIn(padIn), .sfIn(sfIn),
      .opMode(opMode), .optExtReset(optExtReset), .optClkOut(optClkOut), .optPwm(optPwm),
      .optBuzzer(optBuzzer), .padOut(padOut), .route(route), .irqReq(irqReq),
      .extResetReq(extResetReq));

   spp_board u_spp_board (.clk_sys(clk_sys), .padOut(padOut), .extEn(extEn),
      .extVal(extVal), .padIn(padIn));

   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      haddr <= a;
      hwrite <= w;
      htrans <= SPP_HTRANS_NONSEQ;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(a, 1'b1, d, x);
   endtask : wr

   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      ahb(a, 1'b0, 32'h0, d);
      `CHK(n, e, d);
   endtask : rchk

   task automatic st;
      repeat (3) @(posedge clk_sys);
   endtask : st

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      `CHK("irqReq", 0, irqReq);
      `CHK("extResetReq", 0, extResetReq);
      `CHK("hresp", 0, hresp);
      `CHK("hreadyout", 1, hreadyout);
      for (int a = 0; a <= 'h40; a += 4) begin
         if (a != 'h38) rchk("reset value", 8'(a), 0);
      end
   endtask : t_reset

   task automatic t_io;
      wr(SPP_OFF_DIR, 0);
      wr(SPP_OFF_DATA, 'h2a);
      st;
      `CHK("outEn", 6'h3f, padOut.outEn);
      `CHK("dataOut", 6'h2a, padOut.dataOut);
      rchk("port read", SPP_OFF_DATA, 'h2a);
      extEn <= 0;
      wr(SPP_OFF_DIR, 'h3f);
      wr(SPP_OFF_PULLUP, 'h3f);
      wr(SPP_OFF_PULLDN, 'hff);
      st;
      `CHK("pullUpEn", 6'h3f, padOut.pullUpEn);
      `CHK("pullDownEn", 6'h0f, padOut.pullDownEn);
      rchk("pulled read", SPP_OFF_DATA, 'h3f);
      extEn <= 6'h3f;
      wr(SPP_OFF_PULLUP, 0);
      wr(SPP_OFF_PULLDN, 0);
      wr(SPP_OFF_DIR, 0);
      wr(SPP_OFF_ODRAIN, 'h3f);
      wr(SPP_OFF_DATA, 'h15);
      st;
      `CHK("open drain outEn", 6'h2a, padOut.outEn);
      wr(SPP_OFF_ODRAIN, 0);
   endtask : t_io

   task automatic t_read;
      wr(SPP_OFF_DATA, 'h3f);
      wr(SPP_OFF_DIR, 'h3f);
      st;
      rchk("pin read", SPP_OFF_DATA, 0);
      wr(SPP_OFF_MISC, 1);
      rchk("latch read", SPP_OFF_DATA, 'h3f);
      wr(SPP_OFF_MISC, 'h3c0);
      st;
      `CHK("misc route", 4'hf, {route.cmp0, route.cmp2, route.capConnect, route.capDischarge});
      wr(SPP_OFF_MISC, 0);
   endtask : t_read

   task automatic t_irq;
      wr(SPP_OFF_WAKE, 2);
      wr(SPP_OFF_IRQE, 2);
      wr(SPP_OFF_PWR, 'h80);
      wr(SPP_OFF_IRQF, 0);
      extVal <= 2;
      st;
      rchk("change flag", SPP_OFF_IRQF, 2);
      `CHK("irqReq", 1, irqReq);
      wr(SPP_OFF_PWR, 0);
      st;
      `CHK("irqReq no global", 0, irqReq);
      wr(SPP_OFF_WAKE, 1);
      wr(SPP_OFF_EDGE, 'h11);
      wr(SPP_OFF_IRQF, 0);
      extVal <= 3;
      st;
      rchk("rise on falling select", SPP_OFF_IRQF, 0);
      extVal <= 2;
      st;
      rchk("fall flag", SPP_OFF_IRQF, 4);
      wr(SPP_OFF_EDGE, 'h10);
      wr(SPP_OFF_IRQF, 0);
      extVal <= 3;
      st;
      rchk("rise flag", SPP_OFF_IRQF, 4);
      wr(SPP_OFF_WAKE, 3);
      wr(SPP_OFF_IRQF, 0);
      extVal <= 1;
      st;
      rchk("pin1 change kept", SPP_OFF_IRQF, 2);
      wr(SPP_OFF_WAKE, 0);
      wr(SPP_OFF_EDGE, 0);
      wr(SPP_OFF_IRQF, 0);
      extVal <= 0;
   endtask : t_irq

   task automatic t_special;
      wr(SPP_OFF_DIR, 0);
      wr(SPP_OFF_DATA, 0);
      sfIn.carrier <= 1'b1;
      wr(SPP_OFF_CARR, 1);
      st;
      `CHK("carrier pin", 1, padOut.dataOut[3]);
      wr(SPP_OFF_CARR, 0);
      st;
      `CHK("latch pin", 0, padOut.dataOut[3]);
      optPwm <= 1'b1;
      sfIn.pwm <= 1'b1;
      wr(SPP_OFF_TMRB, 'h80);
      st;
      `CHK("pwm pin", 1, padOut.dataOut[2]);
      wr(SPP_OFF_TMRB, 0);
      optBuzzer <= 1'b1;
      sfIn.buzzer <= 1'b1;
      wr(SPP_OFF_BUZZ, 'h80);
      st;
      `CHK("buzzer pin", 1, padOut.dataOut[2]);
      optBuzzer <= 1'b0;
      optClkOut <= 1'b1;
      sfIn.instrClk <= 1'b1;
      st;
      `CHK("buzzer no option", 0, padOut.dataOut[2]);
      `CHK("clock pin normal", 1, padOut.dataOut[4]);
      opMode <= 2'h1;
      st;
      `CHK("clock pin halt", 0, padOut.dataOut[4]);
      opMode <= SPP_MODE_STANDBY;
      st;
      `CHK("clock pin standby", 1, padOut.dataOut[4]);
      optClkOut <= 1'b0;
      opMode <= SPP_MODE_NORMAL;
   endtask : t_special

   task automatic t_pins;
      wr(SPP_OFF_DIR, 'h3f);
      optExtReset <= 1'b1;
      st;
      `CHK("reset low", 1, extResetReq);
      extVal <= 'h28;
      wr(SPP_OFF_TMRSEL, 'h20);
      st;
      `CHK("reset high", 0, extResetReq);
      `CHK("timer A clk", 1, route.timerAClk);
      wr(SPP_OFF_TMRSEL, 'ha0);
      st;
      `CHK("timer A lowclk", 0, route.timerAClk);
      wr(SPP_OFF_TMRSEL, 'h10);
      st;
      `CHK("timer B clk", 1, route.timerBClk);
      optExtReset <= 1'b0;
      extVal <= 0;
      st;
      `CHK("timer B low", 0, route.timerBClk);
      `CHK("reset no option", 0, extResetReq);
      wr(SPP_OFF_DIR, 0);
      wr(SPP_OFF_TOUCH, 2);
      st;
      `CHK("touch pin2", 6'h3b, padOut.outEn);
      wr(SPP_OFF_TOUCH, 'h0f);
      st;
      `CHK("touch all", 6'h0a, padOut.outEn);
      `CHK("touch route", 4'hf, route.touchPad);
      rchk("touch reg", SPP_OFF_TOUCH, 'h0f);
      wr(8'h44, 'ha5);
      rchk("scratch", 8'h44, 'ha5);
   endtask : t_pins

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   initial begin
      rst_n <= 1'b0;
      hsel <= 1'b1;
      haddr <= 0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= 0;
      sfIn <= '0;
      opMode <= SPP_MODE_NORMAL;
      {optExtReset, optClkOut, optPwm, optBuzzer} <= 4'h0;
      extEn <= 6'h3f;
      extVal <= 0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_io;
      t_read;
      t_irq;
      t_special;
      t_pins;
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      badCount++;
      complete_run;
   end
endmodule : spp_port_tb_top
